// File: logic/data_mem_control_pkg.sv
package data_mem_control_pkg;
  // ****************************************************************
  // Control register layout (bit 0 of the printed map is the MSB)
  // ****************************************************************
  localparam int CTL_W = 8;            // Register width
  localparam int BIT_ENABLE = 7;       // Base-compare decode enable
  localparam int BIT_FWD_DIS = 6;      // Load forward disable
  localparam int BIT_BUSY = 5;         // Busy status, read only
  localparam int BIT_AUTO = 4;         // Auto ratio detect, enhanced only
  localparam int RATIO_W_BASIC = 3;    // Ratio field width, basic
  localparam int RATIO_W_ENH = 4;      // Ratio field width, enhanced
  localparam logic [7:0] CTL_RESET = 8'h00;  // Value after reset
  // ****************************************************************
  // Ratio encoding: code = 2n - 1, n = cpu clocks per memory clock
  // ****************************************************************
  localparam logic [3:0] RATIO_1_TO_1 = 4'h1;
  localparam logic [3:0] RATIO_2_TO_1 = 4'h3;
  localparam logic [3:0] RATIO_3_TO_1 = 4'h5;
  localparam logic [3:0] RATIO_4_TO_1 = 4'h7;
  localparam logic [3:0] MAX_N_BASIC = 4'h4;  // Basic tops out at 4:1
  localparam logic [3:0] MAX_N_ENH = 4'h8;    // Enhanced tops out at 8:1
  localparam logic [3:0] DET_CNT_RESET = 4'h1;  // Detector count start
endpackage : data_mem_control_pkg

// File: logic/data_mem_control.sv
module data_mem_control
  import data_mem_control_pkg::*;
#(
  parameter bit ENHANCED = 1'b1  // 1: auto-detect variant, 0: basic
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // Device control register access
  input wire logic ctl_wr_en,
  input wire logic ctl_rd_en,
  input wire logic [7:0] ctl_wr_data,
  output logic [7:0] ctl_rd_data_q,
  output logic ctl_rd_ack_q,
  // Data-side access from the core
  input wire logic acc_req,
  input wire logic [7:0] acc_addr_hi,
  input wire logic [7:0] data_base_compare,
  // Memory side
  input wire logic mem_clk_tick,
  input wire logic [31:0] mem_rd_data,
  output logic mem_claim_q,
  output logic data_mem_busy_flag_q,
  // Load data toward the core
  output logic [31:0] load_data_q,
  output logic load_valid_q
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Cpu clocks per memory clock from a 2n-1 code; even codes round up
  function automatic logic [3:0] code_to_clocks(input logic [3:0] code);
    code_to_clocks = 4'((code >> 1) + 4'h1);
  endfunction : code_to_clocks

  // 2n-1 code from a clock count
  function automatic logic [3:0] clocks_to_code(input logic [3:0] n);
    clocks_to_code = 4'((n << 1) - 4'h1);
  endfunction : clocks_to_code

  localparam logic [3:0] MAX_N = ENHANCED ? MAX_N_ENH : MAX_N_BASIC;

  // ****************************************************************
  // State
  // ****************************************************************
  logic en_q, en_d;                  // Decode enable
  logic fwd_dis_q, fwd_dis_d;        // Load forward disable
  logic auto_q, auto_d;              // Auto detect enable
  logic [3:0] ratio_wr_q, ratio_wr_d;  // Software ratio code
  logic [3:0] det_code_q, det_code_d;  // Detected ratio code
  logic [3:0] det_cnt_q, det_cnt_d;    // Clocks since last tick
  logic [3:0] xfer_cnt_q, xfer_cnt_d;  // Clocks left in transfer
  logic busy_d, claim_d;
  logic [31:0] hold_q, hold_d;       // Extra latch, forward disabled
  logic hold_v_q, hold_v_d;
  logic [31:0] load_data_d;
  logic load_valid_d;
  logic [7:0] rd_data_d;
  logic rd_ack_d;
  logic auto_on;                     // Auto detect in force
  logic [3:0] ratio_eff;             // Code that times transfers
  logic accept, fin;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    auto_on = ENHANCED && auto_q;
    // Basic variant only has three ratio bits
    ratio_eff = auto_on ? det_code_q :
      (ENHANCED ? ratio_wr_q : {1'b0, ratio_wr_q[2:0]});
    en_d = en_q;
    fwd_dis_d = fwd_dis_q;
    auto_d = auto_q;
    ratio_wr_d = ratio_wr_q;
    // Software owns only the writable fields
    if (ctl_wr_en) begin
      en_d = ctl_wr_data[BIT_ENABLE];
      fwd_dis_d = ctl_wr_data[BIT_FWD_DIS];
      // Bits 3 and 4 are reserved in the basic variant and dropped
      auto_d = ENHANCED ? ctl_wr_data[BIT_AUTO] : 1'b0;
      ratio_wr_d = ENHANCED ? ctl_wr_data[3:0]
                            : {1'b0, ctl_wr_data[2:0]};
    end
    // Detector measures cpu clocks between memory clock ticks
    det_code_d = det_code_q;
    det_cnt_d = det_cnt_q;
    if (mem_clk_tick) begin
      // Ratios above the variant's ceiling clamp to it
      det_code_d = clocks_to_code(
        (det_cnt_q > MAX_N) ? MAX_N : det_cnt_q);
      det_cnt_d = DET_CNT_RESET;
    end else if (det_cnt_q != 4'hf) begin
      det_cnt_d = det_cnt_q + 4'h1;  // Saturates, no wrap
    end
    // Claim only matching accesses while decode is on
    accept = acc_req && en_q && (acc_addr_hi == data_base_compare)
             && (xfer_cnt_q == 4'h0);
    fin = (xfer_cnt_q == 4'h1);
    claim_d = accept;
    xfer_cnt_d = xfer_cnt_q;
    if (accept) begin
      xfer_cnt_d = code_to_clocks(ratio_eff);
    end else if (xfer_cnt_q != 4'h0) begin
      xfer_cnt_d = xfer_cnt_q - 4'h1;
    end
    busy_d = (xfer_cnt_d != 4'h0);
    // Load return path
    hold_d = hold_q;
    hold_v_d = 1'b0;
    load_data_d = load_data_q;
    load_valid_d = 1'b0;
    if (fin && !fwd_dis_q) begin
      // Steering path straight to the output latch
      load_data_d = mem_rd_data;
      load_valid_d = 1'b1;
    end else if (fin) begin
      // Direct latch first; costs one more cycle
      hold_d = mem_rd_data;
      hold_v_d = 1'b1;
    end
    if (hold_v_q) begin
      load_data_d = hold_q;
      load_valid_d = 1'b1;
    end
    // Read-back image
    rd_data_d = ctl_rd_data_q;
    rd_ack_d = ctl_rd_en;
    if (ctl_rd_en) begin
      rd_data_d = CTL_RESET;
      rd_data_d[BIT_ENABLE] = en_q;
      rd_data_d[BIT_FWD_DIS] = fwd_dis_q;
      rd_data_d[BIT_BUSY] = data_mem_busy_flag_q;
      rd_data_d[BIT_AUTO] = auto_on;
      if (ENHANCED) begin
        rd_data_d[3:0] = auto_on ? det_code_q
                                 : ratio_wr_q;
      end else begin
        rd_data_d[2:0] = ratio_wr_q[2:0];  // Bit 3/4 slots read zero
      end
    end
  end

  // ****************************************************************
  // Registers; reset wins over ce, otherwise everything holds while ce is low
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_q <= CTL_RESET[BIT_ENABLE];
      fwd_dis_q <= CTL_RESET[BIT_FWD_DIS];
      auto_q <= CTL_RESET[BIT_AUTO];
      ratio_wr_q <= CTL_RESET[3:0];
      det_code_q <= RATIO_1_TO_1;
      det_cnt_q <= DET_CNT_RESET;
      xfer_cnt_q <= 4'h0;
      data_mem_busy_flag_q <= 1'b0;
      mem_claim_q <= 1'b0;
      hold_q <= 32'h0;
      hold_v_q <= 1'b0;
      load_data_q <= 32'h0;
      load_valid_q <= 1'b0;
      ctl_rd_data_q <= CTL_RESET;
      ctl_rd_ack_q <= 1'b0;
    end else if (ce) begin
      en_q <= en_d;
      fwd_dis_q <= fwd_dis_d;
      auto_q <= auto_d;
      ratio_wr_q <= ratio_wr_d;
      det_code_q <= det_code_d;
      det_cnt_q <= det_cnt_d;
      xfer_cnt_q <= xfer_cnt_d;
      data_mem_busy_flag_q <= busy_d;
      mem_claim_q <= claim_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      load_data_q <= load_data_d;
      load_valid_q <= load_valid_d;
      ctl_rd_data_q <= rd_data_d;
      ctl_rd_ack_q <= rd_ack_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_no_claim_off;
    @(posedge ref_clk) disable iff (reset)
      (ce && acc_req && !en_q) |=> !mem_claim_q;
  endproperty
  a_no_claim_off: assert property (p_no_claim_off)
    else $error("access claimed while decode disabled");

  property p_fwd_one_cycle;
    @(posedge ref_clk) disable iff (reset)
      (ce && fin && !fwd_dis_q) |=> load_valid_q;
  endproperty
  a_fwd_one_cycle: assert property (p_fwd_one_cycle)
    else $error("forwarded load not ready after one cycle");

  property p_nofwd_two_cycles;
    @(posedge ref_clk) disable iff (reset)
      (ce && fin && fwd_dis_q) ##1 ce |=> load_valid_q;
  endproperty
  a_nofwd_two_cycles: assert property (p_nofwd_two_cycles)
    else $error("latched load not ready after two cycles");

  property p_busy_readback;
    @(posedge ref_clk) disable iff (reset)
      (ce && ctl_rd_en) |=>
        ctl_rd_data_q[BIT_BUSY] == $past(data_mem_busy_flag_q);
  endproperty
  a_busy_readback: assert property (p_busy_readback)
    else $error("busy bit read back differs from flag");

  property p_ratio_timing;
    @(posedge ref_clk) disable iff (reset)
      (ce && accept) |=> xfer_cnt_q == code_to_clocks($past(ratio_eff))
                         && data_mem_busy_flag_q;
  endproperty
  a_ratio_timing: assert property (p_ratio_timing)
    else $error("transfer length does not follow ratio");

  property p_auto_readback;
    @(posedge ref_clk) disable iff (reset)
      (ce && ctl_rd_en && auto_on) |=> ctl_rd_data_q[3:0] == $past(det_code_q);
  endproperty
  a_auto_readback: assert property (p_auto_readback)
    else $error("auto ratio read back wrong");

  property p_manual_readback;
    @(posedge ref_clk) disable iff (reset)
      (ce && ENHANCED && ctl_rd_en && !auto_on) |=>
        ctl_rd_data_q[3:0] == $past(ratio_wr_q);
  endproperty
  a_manual_readback: assert property (p_manual_readback)
    else $error("manual ratio read back wrong");

  property p_det_code_legal;
    @(posedge ref_clk) disable iff (reset)
      det_code_q[0] && det_code_q <= clocks_to_code(MAX_N);
  endproperty
  a_det_code_legal: assert property (p_det_code_legal)
    else $error("detected ratio code illegal");

  property p_write_keeps_det;
    @(posedge ref_clk) disable iff (reset)
      (ce && ctl_wr_en && !mem_clk_tick) |=> $stable(det_code_q);
  endproperty
  a_write_keeps_det: assert property (p_write_keeps_det)
    else $error("software write changed detected ratio");

endmodule : data_mem_control

// File: verification/mem_side_model.sv
module mem_side_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Ratio chosen by the bench, transfer state from the block
  input wire logic [3:0] ratio_n,
  input wire logic busy,
  // Memory side
  output logic tick,
  output logic [31:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // Memory clock and read data
  // ************************************************
  localparam logic [31:0] WORD = 32'h5a3c_96e1;  // Word of a transfer
  logic [3:0] cnt_q;  // Cpu clocks since the last tick
  // Whole cpu clocks per memory clock only
  always_ff @(posedge ref_clk) begin
    if (reset || cnt_q >= ratio_n - 4'h1) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // At 1:1 the count never leaves zero, so the tick stays high
  assign tick = (cnt_q == 4'h0);
  // Idle bus shows the inverse word so a late sample cannot pass
  assign rd_data = busy ? WORD : ~WORD;
endmodule : mem_side_model

// File: verification/data_mem_control_bench.sv
module data_mem_control_bench;
  import data_mem_control_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] WORD = 32'h5a3c_96e1;  // Model's word
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;  // Low in the freeze scenario only
  logic ctl_wr_en = 1'b0;
  logic ctl_rd_en = 1'b0;
  logic [7:0] ctl_wr_data = 8'h00;
  logic [7:0] ctl_rd_data_q;
  logic ctl_rd_ack_q;
  logic acc_req = 1'b0;
  logic [7:0] acc_addr_hi = 8'h00;
  logic [7:0] base = 8'h3c;  // Base compare value
  logic tick;
  logic [31:0] mem_rd_data;
  logic mem_claim_q, data_mem_busy_flag_q, load_valid_q;
  logic [31:0] load_data_q;
  logic [3:0] ratio_n = 4'h2;  // Cpu clocks per memory clock
  int fails = 0;
  int n_checks = 0;
  data_mem_control DUT (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .ctl_wr_en(ctl_wr_en), .ctl_rd_en(ctl_rd_en),
    .ctl_wr_data(ctl_wr_data), .ctl_rd_data_q(ctl_rd_data_q),
    .ctl_rd_ack_q(ctl_rd_ack_q), .acc_req(acc_req),
    .acc_addr_hi(acc_addr_hi), .data_base_compare(base),
    .mem_clk_tick(tick), .mem_rd_data(mem_rd_data),
    .mem_claim_q(mem_claim_q), .data_mem_busy_flag_q(data_mem_busy_flag_q),
    .load_data_q(load_data_q), .load_valid_q(load_valid_q));
  mem_side_model mem (.ref_clk(ref_clk), .reset(reset), .ratio_n(ratio_n),
    .busy(data_mem_busy_flag_q), .tick(tick), .rd_data(mem_rd_data));
  // Basic variant beside it; its write data keeps bits 3 and 4 at zero
  logic [7:0] b_rd_data;
  logic b_rd_ack, b_claim, b_busy, b_load_valid;
  logic [31:0] b_load_data;
  int b_loads = 0;  // Load pulses seen from the basic variant
  data_mem_control #(.ENHANCED(1'b0)) DUT_basic (.ref_clk(ref_clk),
    .reset(reset), .ce(ce), .ctl_wr_en(ctl_wr_en), .ctl_rd_en(ctl_rd_en),
    .ctl_wr_data(ctl_wr_data & 8'he7),
    .ctl_rd_data_q(b_rd_data), .ctl_rd_ack_q(b_rd_ack), .acc_req(acc_req),
    .acc_addr_hi(acc_addr_hi), .data_base_compare(base),
    .mem_clk_tick(tick), .mem_rd_data(mem_rd_data),
    .mem_claim_q(b_claim), .data_mem_busy_flag_q(b_busy),
    .load_data_q(b_load_data), .load_valid_q(b_load_valid));
  // ************************************************
  // Clock and helpers
  // ************************************************
  always #12.5 ref_clk = ~ref_clk;
  // Counts the basic variant's load pulses, which may come early
  always @(negedge ref_clk) begin
    if (b_load_valid === 1'b1) begin
      b_loads++;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Strobes rise after a falling edge and drop one cycle later
  task automatic wr(input logic [7:0] d);
    ctl_wr_data = d;
    ctl_wr_en = 1'b1;
    @(negedge ref_clk);
    ctl_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] e, input logic [7:0] eb);
    ctl_rd_en = 1'b1;
    @(negedge ref_clk);
    ctl_rd_en = 1'b0;
    check(ctl_rd_ack_q, 1'b1);
    check(ctl_rd_data_q, e);
    check(b_rd_ack, 1'b1);
    check(b_rd_data, eb);
  endtask : rd
  // One access; n = 0 means it must not be claimed, nb is the basic length
  task automatic access(input int n, input int nb, input int lat,
                        input logic [7:0] a);
    int b;
    int bb;
    int l;
    int v0;
    v0 = b_loads;
    acc_addr_hi = a;
    acc_req = 1'b1;
    @(negedge ref_clk);
    acc_req = 1'b0;
    check(mem_claim_q, n > 0);
    check(data_mem_busy_flag_q, n > 0);
    check(b_claim, nb > 0);
    check(b_busy, nb > 0);
    b = 0;
    bb = 0;
    while (data_mem_busy_flag_q === 1'b1 && b < 20) begin
      b++;
      if (b_busy === 1'b1) begin
        bb++;
      end
      @(negedge ref_clk);
    end
    check(b, n);
    check(bb, nb);
    if (n == 0) begin
      // Let an edge pass so a following request is a fresh one
      @(negedge ref_clk);
      check(b_loads, v0);
      return;
    end
    l = 1;
    while (load_valid_q !== 1'b1 && l < 5) begin
      l++;
      @(negedge ref_clk);
    end
    check(l, lat);
    check(load_data_q, WORD);
    if (b == 20 || l == 5) begin
      stop_test();
    end
    @(negedge ref_clk);
    check(b_load_data, WORD);
    check(b_loads, v0 + 1);
  endtask : access
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_fields();
    rd(8'h00, 8'h00);
    wr(8'h25);
    rd(8'h05, 8'h05);
    // A write while ce is low must leave every field alone
    ce = 1'b0;
    wr(8'hc1);
    ce = 1'b1;
    rd(8'h05, 8'h05);
  endtask : t_fields
  // Every odd code times n = (code + 1) / 2 clocks, up to 8:1
  task automatic t_timing();
    for (int c = 1; c < 16; c += 2) begin
      wr(8'h80 | 8'(c));
      access(c / 2 + 1, (c % 8) / 2 + 1, 1, base);
    end
    // An even code times like the odd code above it
    wr(8'h82);
    access(2, 2, 1, base);
    wr(8'hc5);
    access(3, 3, 2, base);
  endtask : t_timing
  task automatic t_decode();
    wr(8'h43);
    access(0, 0, 0, base);
    wr(8'h83);
    access(0, 0, 0, base ^ 8'h01);
    access(2, 2, 1, base);
  endtask : t_decode
  // The enhanced variant reads back the detected code, not the value written; the basic variant reads back the written value
  task automatic t_auto();
    for (int n = 3; n < 9; n += 5) begin
      ratio_n = 4'(n);
      wr(8'h9a);
      repeat (40) @(negedge ref_clk);
      rd(8'h90 | 8'(2 * n - 1), 8'h82);
    end
    wr(8'h06);
    rd(8'h06, 8'h06);
  endtask : t_auto
  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    t_fields();
    t_timing();
    t_decode();
    t_auto();
    stop_test();
  end
endmodule : data_mem_control_bench
